//--- shared/gpiob_pkg.sv
// Package of constants for the multi-port pin block.
package gpiob_pkg;
   // ==========================================================================
   // Geometry
   localparam int NPORT = 12;
   localparam int PW    = 8;
   localparam int NREG  = 5;

   // ==========================================================================
   // Port numbers with special behaviour
   localparam int P_ZERO  = 0;
   localparam int P_ONE   = 1;
   localparam int P_THREE = 3;
   localparam int P_FOUR  = 4;
   localparam int P_FIVE  = 5;
   localparam int P_B     = 11;

   // ==========================================================================
   // Register indices; the byte address of an index is four times the index.
   localparam logic [31:0] IDX_PORT5_INPUT_ENABLE = 32'hFFFF_F05E;
   localparam int          IDX_W         = 12;
   localparam logic [11:0] IDX_PORT_BASE = 12'h100;
   localparam logic [11:0] IDX_STRIDE    = 12'h008;
   localparam int          OFS_DATA      = 0;
   localparam int          OFS_DIR       = 1;
   localparam int          OFS_FNA       = 2;
   localparam int          OFS_FNB       = 3;
   localparam int          OFS_IE        = 4;

   // ==========================================================================
   // Per-port features, bit p stands for port p (ports 7 to A are analog).
   localparam logic [11:0] HAS_DIR   = 12'h87F;
   localparam logic [11:0] HAS_FNB   = 12'h006;
   localparam logic [11:0] IE_GATED  = 12'hFFC;
   localparam logic [11:0] LATCH_ONE = 12'h064;

   // ==========================================================================
   // Reset values
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONES = 8'hFF;
   localparam logic [7:0] IE_RESET  = 8'h00;

   // ==========================================================================
   // Bit positions of fixed alternate functions
   localparam int RD_BIT   = 0;
   localparam int WR_BIT   = 1;
   localparam int NCS      = 6;
   localparam int SCLK_BIT = 6;
endpackage

//--- hdl/gpiob_ports.sv
// Register file and pin multiplexers for general-purpose ports 0 to B.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps

// Overview of operation
// - Pins of ports 0 to 6 and B individually set input or output.
// - Function bit one routes pin to alternate.
// - Input passes only when input enable set.
// - Disabled input reads as one.
// - Ports 0 and 1 need no enable.
// - Port 0 direction clears at reset.
// - External access forces port 0 functions on.
// - Strap picks port 0 data or multiplexed.
// - Port 1 latch, direction, functions clear.
// - Strap picks port 1 bus mode.
// - Port 2 latch ones, controls clear.
// - Strap picks port 2 address range.
// - Strobes only during external area access.
// - Port 4 drives chip selects and clock.
// - Port 5 latch ones, controls clear.
// - Port 5 input enable is read-write, zero.
// - Port 6 latch ones, carries address.
// - Ports 7 to A analog, input disabled.
// - Port B latch and controls clear.
// - Port B function routes timer inputs.
module gpiob_ports (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [31:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic      [31:0]  prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [95:0]  pin_in,
   output wire logic [95:0]  pin_out,
   output wire logic [95:0]  pin_oe,
   input  wire logic [95:0]  alt_out,
   input  wire logic [95:0]  alt_oe,
   output wire logic [95:0]  alt_in,
   input  wire logic         bus_mode_strap,
   input  wire logic         ext_mem_access,
   input  wire logic         ext_area_access,
   input  wire logic         read_strobe_n,
   input  wire logic         write_strobe_n,
   input  wire logic [5:0]   chip_select_n,
   input  wire logic         system_clock_output,
   output logic              bus_mode_mux,
   output wire logic [7:0]   timer_input
);

   // ==========================================================================
   // Bus decode
   logic [11:0] idx;
   logic        setup;
   logic        wr_go;
   logic        strap_taken;
   logic        next_strap_taken;
   logic        next_bus_mode_mux;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        any_hit;
   wire  [7:0]  rd_p [gpiob_pkg::NPORT];
   wire         hit_p [gpiob_pkg::NPORT];

   assign idx   = paddr[13:2];
   assign setup = psel & ~penable;
   assign wr_go = psel & penable & pready & pwrite;

   // ==========================================================================
   // Per-port logic
   genvar p;
   generate
      for (p = 0; p < gpiob_pkg::NPORT; p++) begin : g_port
         localparam logic [11:0] BASE = gpiob_pkg::IDX_PORT_BASE + 12'(p) * gpiob_pkg::IDX_STRIDE;
         localparam logic [7:0]  LRST = gpiob_pkg::LATCH_ONE[p] ? gpiob_pkg::BYTE_ONES : gpiob_pkg::BYTE_ZERO;
         logic [7:0]  latch;
         logic [7:0]  dir;
         logic [7:0]  fna;
         logic [7:0]  fnb;
         logic [7:0]  ie;
         logic [7:0]  pout;
         logic [7:0]  poe;
         logic [7:0]  ain;
         logic [7:0]  next_latch;
         logic [7:0]  next_dir;
         logic [7:0]  next_fna;
         logic [7:0]  next_fnb;
         logic [7:0]  next_ie;
         logic [7:0]  next_pout;
         logic [7:0]  next_poe;
         logic [7:0]  pin;
         logic [7:0]  gated;
         logic [7:0]  sel;
         logic [7:0]  av;
         logic [7:0]  ao;
         logic [7:0]  rv;
         logic        h_dat;
         logic        h_dir;
         logic        h_fna;
         logic        h_fnb;
         logic        h_ie;

         assign pin   = pin_in[p*8 +: 8];
         assign h_dat = idx == BASE + 12'(gpiob_pkg::OFS_DATA);
         assign h_dir = gpiob_pkg::HAS_DIR[p] && idx == BASE + 12'(gpiob_pkg::OFS_DIR);
         assign h_fna = gpiob_pkg::HAS_DIR[p] && idx == BASE + 12'(gpiob_pkg::OFS_FNA);
         assign h_fnb = gpiob_pkg::HAS_FNB[p] && idx == BASE + 12'(gpiob_pkg::OFS_FNB);
         assign h_ie  = gpiob_pkg::IE_GATED[p] &&
                        ((p == gpiob_pkg::P_FIVE) ? idx == gpiob_pkg::IDX_PORT5_INPUT_ENABLE[11:0]
                                                  : idx == BASE + 12'(gpiob_pkg::OFS_IE));
         // Ports 0 and 1 pass the pin straight; others read one while disabled.
         assign gated = gpiob_pkg::IE_GATED[p] ? ((pin & ie) | ~ie) : pin;
         // Both function banks of port 1 are ORed; setting both at once is undefined.
         assign sel   = fna | fnb;

         always_comb begin
            av = alt_out[p*8 +: 8];
            ao = alt_oe[p*8 +: 8];
            if (p == gpiob_pkg::P_THREE) begin
               av[gpiob_pkg::RD_BIT] = ~ext_area_access | read_strobe_n;
               av[gpiob_pkg::WR_BIT] = ~ext_area_access | write_strobe_n;
               ao[gpiob_pkg::RD_BIT] = 1'b1;
               ao[gpiob_pkg::WR_BIT] = 1'b1;
            end
            if (p == gpiob_pkg::P_FOUR) begin
               av[gpiob_pkg::NCS-1:0]  = chip_select_n;
               av[gpiob_pkg::SCLK_BIT] = system_clock_output;
               ao[gpiob_pkg::SCLK_BIT:0] = {(gpiob_pkg::NCS+1){1'b1}};
            end
         end

         always_comb begin
            next_latch = latch;
            next_dir   = dir;
            next_fna   = fna;
            next_fnb   = fnb;
            next_ie    = ie;
            if (wr_go && h_dat && gpiob_pkg::HAS_DIR[p]) begin
               next_latch = pwdata[7:0];
            end
            if (wr_go && h_dir) begin
               next_dir = pwdata[7:0];
            end
            if (wr_go && h_fna) begin
               next_fna = pwdata[7:0];
            end
            if (wr_go && h_fnb) begin
               next_fnb = pwdata[7:0];
            end
            if (wr_go && h_ie) begin
               next_ie = pwdata[7:0];
            end
            if (p == gpiob_pkg::P_ZERO && ext_mem_access) begin
               next_fna = gpiob_pkg::BYTE_ONES;
            end
            // The owning peripheral drives both value and enable when selected.
            next_pout = (sel & av) | (~sel & latch);
            next_poe  = (sel & ao) | (~sel & dir);
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               latch <= LRST;
               dir   <= gpiob_pkg::BYTE_ZERO;
               fna   <= gpiob_pkg::BYTE_ZERO;
               fnb   <= gpiob_pkg::BYTE_ZERO;
               ie    <= gpiob_pkg::IE_RESET;
               pout  <= LRST;
               poe   <= gpiob_pkg::BYTE_ZERO;
               ain   <= gpiob_pkg::BYTE_ZERO;
            end else begin
               latch <= next_latch;
               dir   <= next_dir;
               fna   <= next_fna;
               fnb   <= next_fnb;
               ie    <= next_ie;
               pout  <= next_pout;
               poe   <= next_poe;
               ain   <= gated & sel;
            end
         end

         // An output bit not routed to its alternate reads its latch, any other bit the gated pin level.
         assign rv = h_dat ? ((dir & ~sel & latch) | (~(dir & ~sel) & gated)) :
                     h_dir ? dir : h_fna ? fna : h_fnb ? fnb : h_ie ? ie : gpiob_pkg::BYTE_ZERO;
         assign rd_p[p]  = rv;
         assign hit_p[p] = h_dat | h_dir | h_fna | h_fnb | h_ie;
         assign pin_out[p*8 +: 8] = pout;
         assign pin_oe[p*8 +: 8]  = poe;
         assign alt_in[p*8 +: 8]  = ain;
      end
   endgenerate

   assign timer_input = g_port[gpiob_pkg::P_B].ain;

   // ==========================================================================
   // Bus slave and strap capture
   always_comb begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      next_pready  = setup;
      any_hit      = 1'b0;
      for (int i = 0; i < gpiob_pkg::NPORT; i++) begin
         any_hit = any_hit | hit_p[i];
         if (hit_p[i]) begin
            next_prdata[7:0] = next_prdata[7:0] | rd_p[i];
         end
      end
      if (!setup) begin
         next_prdata = prdata;
      end else if (!any_hit) begin
         next_pslverr = 1'b1;
      end
      next_strap_taken  = 1'b1;
      // The bus controller routes ports 0, 1 and 2 by this latched mode.
      next_bus_mode_mux = strap_taken ? bus_mode_mux : bus_mode_strap;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata       <= 32'h0000_0000;
         pready       <= 1'b0;
         pslverr      <= 1'b0;
         strap_taken  <= 1'b0;
         bus_mode_mux <= 1'b0;
      end else begin
         prdata       <= next_prdata;
         pready       <= next_pready;
         pslverr      <= next_pslverr;
         strap_taken  <= next_strap_taken;
         bus_mode_mux <= next_bus_mode_mux;
      end
   end

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_first;
      !strap_taken;
   endsequence
   sequence s_read_p5_masked;
      s_setup ##0 (!pwrite && idx == gpiob_pkg::IDX_PORT_BASE + 12'(gpiob_pkg::P_FIVE) * gpiob_pkg::IDX_STRIDE
                   && g_port[gpiob_pkg::P_FIVE].ie == 8'h00 && g_port[gpiob_pkg::P_FIVE].dir == 8'h00
                   && g_port[gpiob_pkg::P_FIVE].sel == 8'h00);
   endsequence

   property p_apb_ready;
      s_setup |=> pready ##1 !pready;
   endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("pready not one cycle after setup");

   property p_p0_reset;
      s_first |-> g_port[gpiob_pkg::P_ZERO].dir == 8'h00 && pin_oe[7:0] == 8'h00;
   endproperty
   a_p0_reset: assert property (p_p0_reset) else $error("port 0 drives after reset");

   property p_p1_reset;
      s_first |-> g_port[gpiob_pkg::P_ONE].fna == 8'h00 && g_port[gpiob_pkg::P_ONE].fnb == 8'h00
                  && pin_out[15:8] == 8'h00;
   endproperty
   a_p1_reset: assert property (p_p1_reset) else $error("port 1 reset state wrong");

   property p_p2_reset;
      s_first |-> pin_out[23:16] == 8'hFF && pin_oe[23:16] == 8'h00;
   endproperty
   a_p2_reset: assert property (p_p2_reset) else $error("port 2 reset state wrong");

   property p_p5_reset;
      s_first |-> pin_out[47:40] == 8'hFF && g_port[gpiob_pkg::P_FIVE].ie == 8'h00;
   endproperty
   a_p5_reset: assert property (p_p5_reset) else $error("port 5 reset state wrong");

   property p_ext_force;
      ext_mem_access |=> g_port[gpiob_pkg::P_ZERO].fna == 8'hFF ##1 pin_oe[7:0] == $past(alt_oe[7:0]);
   endproperty
   a_ext_force: assert property (p_ext_force) else $error("port 0 not forced to bus");

   property p_masked_read;
      s_read_p5_masked |=> prdata[7:0] == 8'hFF;
   endproperty
   a_masked_read: assert property (p_masked_read) else $error("disabled input not read as one");

   property p_strobe_idle;
      (g_port[gpiob_pkg::P_THREE].fna[0] && !ext_area_access) |=> pin_out[24] && pin_oe[24];
   endproperty
   a_strobe_idle: assert property (p_strobe_idle) else $error("read strobe outside external area");

   property p_chip_select;
      g_port[gpiob_pkg::P_FOUR].fna[0] |=> pin_out[32] == $past(chip_select_n[0]);
   endproperty
   a_chip_select: assert property (p_chip_select) else $error("chip select not routed");

   property p_timer_in;
      (g_port[gpiob_pkg::P_B].fna[0] && g_port[gpiob_pkg::P_B].ie[0]) |=> timer_input[0] == $past(pin_in[88]);
   endproperty
   a_timer_in: assert property (p_timer_in) else $error("timer input not routed");

   property p_analog_quiet;
      1'b1 |-> pin_oe[87:56] == 32'h0000_0000;
   endproperty
   a_analog_quiet: assert property (p_analog_quiet) else $error("analog port driven");

   property p_strap_hold;
      strap_taken |=> $stable(bus_mode_mux);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("bus mode changed after reset");

   property p_p6_reset;
      s_first |-> pin_out[55:48] == 8'hFF && pin_oe[55:48] == 8'h00;
   endproperty
   a_p6_reset: assert property (p_p6_reset) else $error("port 6 reset state wrong");

   property p_pb_reset;
      s_first |-> pin_out[95:88] == 8'h00 && pin_oe[95:88] == 8'h00 && g_port[gpiob_pkg::P_B].fna == 8'h00;
   endproperty
   a_pb_reset: assert property (p_pb_reset) else $error("port B reset state wrong");

   property p_strobe_active;
      (g_port[gpiob_pkg::P_THREE].fna[gpiob_pkg::RD_BIT] && ext_area_access)
         |=> pin_out[24] == $past(read_strobe_n);
   endproperty
   a_strobe_active: assert property (p_strobe_active) else $error("read strobe not passed in external area");

   property p_wr_strobe_idle;
      (g_port[gpiob_pkg::P_THREE].fna[gpiob_pkg::WR_BIT] && !ext_area_access)
         |=> pin_out[25] && pin_oe[25];
   endproperty
   a_wr_strobe_idle: assert property (p_wr_strobe_idle) else $error("write strobe outside external area");

   property p_clock_out;
      g_port[gpiob_pkg::P_FOUR].fna[gpiob_pkg::SCLK_BIT]
         |=> pin_out[38] == $past(system_clock_output) && pin_oe[38];
   endproperty
   a_clock_out: assert property (p_clock_out) else $error("clock output not routed");

   property p_dir_follow;
      g_port[gpiob_pkg::P_ZERO].sel == 8'h00 |=> pin_oe[7:0] == $past(g_port[gpiob_pkg::P_ZERO].dir);
   endproperty
   a_dir_follow: assert property (p_dir_follow) else $error("port 0 enable not from direction");

   property p_alt_drive;
      1'b1 |=> ((pin_oe[95:88] ^ $past(alt_oe[95:88])) & $past(g_port[gpiob_pkg::P_B].sel)) == 8'h00
               && ((pin_out[95:88] ^ $past(alt_out[95:88])) & $past(g_port[gpiob_pkg::P_B].sel)) == 8'h00;
   endproperty
   a_alt_drive: assert property (p_alt_drive) else $error("selected pin not driven by its owner");

   property p_ie_write;
      (psel && penable && pready && pwrite && idx == gpiob_pkg::IDX_PORT5_INPUT_ENABLE[11:0])
         |=> g_port[gpiob_pkg::P_FIVE].ie == $past(pwdata[7:0]);
   endproperty
   a_ie_write: assert property (p_ie_write) else $error("port 5 input enable write lost");

   sequence s_read_p0_plain;
      s_setup ##0 (!pwrite && idx == gpiob_pkg::IDX_PORT_BASE && g_port[gpiob_pkg::P_ZERO].dir == 8'h00
                   && g_port[gpiob_pkg::P_ZERO].sel == 8'h00);
   endsequence

   property p_p0_ungated;
      s_read_p0_plain |=> prdata[7:0] == $past(pin_in[7:0]);
   endproperty
   a_p0_ungated: assert property (p_p0_ungated) else $error("port 0 read not the raw pin level");

   property p_slverr_pair;
      pslverr |-> pready;
   endproperty
   a_slverr_pair: assert property (p_slverr_pair) else $error("error reported outside an answer");

endmodule

//--- test/gpiob_pin_model.sv
// Far-side pad model for the multi-port pin block.
`timescale 1ns/1ps
module gpiob_pin_model (
   input  wire logic [95:0] pin_out,
   input  wire logic [95:0] pin_oe,
   input  wire logic [95:0] ext_lvl,
   output wire logic [95:0] pin_in
);
   // ==========
   // Pad resolution
   // A driven pad reads back the block's own value; an undriven pad shows the outside level.
   // The bench sets that level at random once, just after the first reset is released.
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_lvl);
endmodule

//--- test/gpiob_ports_tb.sv
// Self-checking bench for the multi-port pin block.
`timescale 1ns/1ps
module gpiob_ports_tb;
   // ==========
   // Signals
   logic        pclk                = 1'b0;
   logic        presetn             = 1'b0;
   logic        psel                = 1'b0;
   logic        penable             = 1'b0;
   logic        pwrite              = 1'b0;
   logic [31:0] paddr               = 32'h0000_0000;
   logic [31:0] pwdata              = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [95:0] pin_in;
   logic [95:0] pin_out;
   logic [95:0] pin_oe;
   logic [95:0] alt_in;
   logic [95:0] alt_out             = '0;
   logic [95:0] alt_oe              = '0;
   logic [95:0] ext_lvl             = '0;
   logic        bus_mode_strap      = 1'b0;
   logic        ext_mem_access      = 1'b0;
   logic        ext_area_access     = 1'b0;
   logic        read_strobe_n       = 1'b1;
   logic        write_strobe_n      = 1'b1;
   logic [5:0]  chip_select_n       = 6'h3F;
   logic        system_clock_output = 1'b0;
   logic        bus_mode_mux;
   logic [7:0]  timer_input;
   logic [8:0]  expq[$];
   logic [8:0]  head;
   logic [7:0]  v;
   logic [7:0]  d;
   logic [7:0]  f;
   int          seed                = 71762;
   int          err_count           = 0;
   int          checks_done         = 0;
   localparam logic [31:0] IE5 = {gpiob_pkg::IDX_PORT5_INPUT_ENABLE[29:0], 2'b00};

   always #12.5 pclk = ~pclk;

   gpiob_ports DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe),
      .alt_in(alt_in), .bus_mode_strap(bus_mode_strap), .ext_mem_access(ext_mem_access),
      .ext_area_access(ext_area_access), .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
      .chip_select_n(chip_select_n), .system_clock_output(system_clock_output),
      .bus_mode_mux(bus_mode_mux), .timer_input(timer_input));

   gpiob_pin_model pads (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .pin_in(pin_in));

   // ==========
   // Helpers
   task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
   endtask

   function automatic logic [31:0] ra(input int p, input int o);
      logic [11:0] i;
      i = gpiob_pkg::IDX_PORT_BASE + 12'(p * gpiob_pkg::IDX_STRIDE) + 12'(o);
      return {18'h0_0000, i, 2'b00};
   endfunction

   // One APB transfer; every transfer leaves its expected answer in the queue for the monitor.
   task automatic apb(input logic wr, input logic [31:0] a, input logic [7:0] wd, input logic [8:0] e);
      int n;
      n = 0;
      expq.push_back(e);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h00_0000, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         err_count++;
         results();
      end
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [31:0] a, input logic [7:0] wd);
      apb(1'b1, a, wd, 9'h000);
   endtask

   task automatic rd(input logic [31:0] a, input logic [7:0] e);
      apb(1'b0, a, 8'h00, {1'b0, e});
   endtask

   // ==========
   // Transfer monitor
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1) begin
         if (expq.size() == 0) begin
            check("unexpected transfer", 96'h1, 96'h0);
         end else begin
            head = expq.pop_front();
            if (pwrite) begin
               check("pslverr", 96'(pslverr), 96'(head[8]));
            end else begin
               check("prdata", 96'({pslverr, prdata}), 96'({head[8], 24'h00_0000, head[7:0]}));
            end
         end
      end
   end

   // ==========
   // Main sequence
   initial begin
      repeat (10) @(posedge pclk);
      check("pin_oe in reset", pin_oe, 96'h0);
      presetn <= 1'b1;
      ext_lvl <= {$random(seed), $random(seed), $random(seed)};
      tick(2);
      check("pin_out reset", pin_out, 96'h0000_0000_00FF_FF00_00FF_0000);
      check("bus mode low", 96'(bus_mode_mux), 96'h0);
      for (int p = 0; p < gpiob_pkg::NPORT; p++) begin
         rd(ra(p, gpiob_pkg::OFS_DATA), p < 2 ? ext_lvl[8*p +: 8] : 8'hFF);
         if (gpiob_pkg::HAS_DIR[p]) begin
            rd(ra(p, gpiob_pkg::OFS_DIR), 8'h00);
            rd(ra(p, gpiob_pkg::OFS_FNA), 8'h00);
         end
      end
      // The bench never sets one port 1 bit in both function registers.
      rd(ra(1, gpiob_pkg::OFS_FNB), 8'h00);
      rd(ra(2, gpiob_pkg::OFS_FNB), 8'h00);
      rd(IE5, 8'h00);
      v = 8'($random(seed));
      wr(IE5, v);
      rd(IE5, v);
      rd(ra(5, gpiob_pkg::OFS_DATA), (ext_lvl[47:40] & v) | ~v);
      wr(ra(7, gpiob_pkg::OFS_IE), ~v);
      rd(ra(7, gpiob_pkg::OFS_DATA), (ext_lvl[63:56] & ~v) | v);
      d = 8'($random(seed));
      v = 8'($random(seed));
      wr(ra(0, gpiob_pkg::OFS_DATA), d);
      wr(ra(0, gpiob_pkg::OFS_DIR), v);
      tick(2);
      check("port 0 oe", 96'(pin_oe[7:0]), 96'(v));
      check("port 0 out", 96'(pin_out[7:0] & v), 96'(d & v));
      rd(ra(0, gpiob_pkg::OFS_DATA), (d & v) | (ext_lvl[7:0] & ~v));
      wr(ra(11, gpiob_pkg::OFS_IE), 8'hFF);
      f = 8'($random(seed));
      alt_out <= {$random(seed), $random(seed), $random(seed)};
      alt_oe <= {$random(seed), $random(seed), $random(seed)};
      wr(ra(11, gpiob_pkg::OFS_FNA), f);
      tick(3);
      check("port b oe", 96'(pin_oe[95:88]), 96'(f & alt_oe[95:88]));
      check("port b out", 96'(pin_out[95:88] & f), 96'(alt_out[95:88] & f));
      check("timer input", 96'(timer_input),
         96'(f & ((f & alt_oe[95:88] & alt_out[95:88]) | (~(f & alt_oe[95:88]) & ext_lvl[95:88]))));
      wr(ra(1, gpiob_pkg::OFS_FNB), f);
      tick(3);
      check("port 1 oe", 96'(pin_oe[15:8]), 96'(f & alt_oe[15:8]));
      ext_mem_access <= 1'b1;
      tick(2);
      ext_mem_access <= 1'b0;
      tick(1);
      check("port 0 oe bus", 96'(pin_oe[7:0]), 96'(alt_oe[7:0]));
      rd(ra(0, gpiob_pkg::OFS_FNA), 8'hFF);
      // Pin 2 of port 3 stands for the wait input: its owner never drives it.
      alt_oe[31:24] <= 8'h00;
      wr(ra(3, gpiob_pkg::OFS_FNA), 8'h07);
      tick(3);
      check("wait input gated", 96'(alt_in[26]), 96'h1);
      wr(ra(3, gpiob_pkg::OFS_IE), 8'hFF);
      tick(3);
      check("wait input", 96'(alt_in[26]), 96'(ext_lvl[26]));
      read_strobe_n   <= 1'b0;
      write_strobe_n  <= 1'b0;
      tick(3);
      check("strobes idle", 96'({pin_oe[25:24], pin_out[25:24]}), 96'hF);
      ext_area_access <= 1'b1;
      tick(3);
      check("strobes active", 96'({pin_oe[25:24], pin_out[25:24]}), 96'hC);
      d = 8'($random(seed));
      chip_select_n       <= d[5:0];
      system_clock_output <= d[6];
      wr(ra(4, gpiob_pkg::OFS_FNA), 8'h7F);
      tick(3);
      check("chip selects", 96'({pin_oe[38:32], pin_out[38:32]}), 96'({7'h7F, d[6:0]}));
      // An unmapped word refuses the write and reads as zero with an error.
      apb(1'b1, ra(0, 6), 8'h5A, 9'h100);
      apb(1'b0, ra(0, 6), 8'h00, 9'h100);
      bus_mode_strap <= 1'b1;
      presetn        <= 1'b0;
      tick(2);
      check("pin_oe second reset", pin_oe, 96'h0);
      presetn <= 1'b1;
      tick(2);
      bus_mode_strap <= 1'b0;
      tick(2);
      check("bus mode high", 96'(bus_mode_mux), 96'h1);
      rd(IE5, 8'h00);
      rd(ra(1, gpiob_pkg::OFS_DIR), 8'h00);
      results();
   end
endmodule
